/* File: pkg/amc_pkg.sv */
// constants shared by the arithmetic coprocessor and its divider
// assumes the core issues one coprocessor instruction per cycle on the request port
// Summary of operation
// - 16x16 multiply into 32 bits, signed or unsigned, done in one cycle.
// - signed multiply-accumulate into 32 bits with overflow flag, one cycle per step.
// - 16/16 divide, signed or unsigned, quotient and remainder 18 cycles after the operand-send.
// - mode-write instruction stores source bits 6..0 in mode register, destination ignored.
// - mode bits 6..4 select output half, bits 3..0 select the operation.
// - selector 0 returns low half, 1 returns high half, 2 to 7 reserved.
// - operation 0 clears the whole 32-bit result register.
// - operation 1 loads a 16-bit start value into the low half, high half zero.
// - operation 2 loads a full 32-bit start value into the result register.
// - operation 3 returns the stored result half without changing it.
// - operation 4 multiplies unsigned, operation 5 multiplies signed.
// - operation 7 adds a signed product to the result register.
// - operation 8 divides unsigned, 9 signed; 6 and 10 to 15 reserved.
// - multiply operands come in one operand-send; selected half and flags are returned.
// - after division quotient sits in bits 15..0, remainder in bits 31..16.
// - writing operation 0 clears the result at once, with no operand transfer.
package amc_pkg;
  localparam int DATA_W = 16;
  localparam int RES_W = 32;
  localparam int MODE_W = 7;
  localparam int OP_LSB = 0;
  localparam int OP_W = 4;
  localparam int SEL_LSB = 4;
  localparam int SEL_W = 3;
  localparam logic [MODE_W-1:0] MODE_RESET = 7'h00;
  localparam logic [RES_W-1:0] RES_RESET = 32'h0000_0000;
  localparam logic [SEL_W-1:0] SEL_LOW = 3'h0;
  localparam logic [SEL_W-1:0] SEL_HIGH = 3'h1;
  localparam logic [OP_W-1:0] OP_CLEAR = 4'h0;
  localparam logic [OP_W-1:0] OP_LOAD16 = 4'h1;
  localparam logic [OP_W-1:0] OP_LOAD32 = 4'h2;
  localparam logic [OP_W-1:0] OP_READ = 4'h3;
  localparam logic [OP_W-1:0] OP_MULU = 4'h4;
  localparam logic [OP_W-1:0] OP_MULS = 4'h5;
  localparam logic [OP_W-1:0] OP_MAC = 4'h7;
  localparam logic [OP_W-1:0] OP_DIVU = 4'h8;
  localparam logic [OP_W-1:0] OP_DIVS = 4'h9;
  localparam logic [DATA_W-1:0] RESERVED_ANSWER = 16'h0000;
  // flag vector order {carry, overflow, zero, negative}
  localparam int FLAG_W = 4;
  localparam int FLAG_V = 2;
  localparam logic [FLAG_W-1:0] FLAGS_CLEAR = 4'h0;
  localparam logic [4:0] DIV_STEPS = 5'h10;
  typedef enum logic [1:0] {AMC_DIV_IDLE, AMC_DIV_RUN, AMC_DIV_FIX} amc_div_state_t;
endpackage

/* File: verilog/amc_divider.sv */
// restoring divider, one quotient bit per cycle
// assumes start is a one-cycle pulse while idle; operands held by caller not needed
`timescale 1ns/1ps
module amc_divider (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic is_signed,
  input wire logic [15:0] dividend,
  input wire logic [15:0] divisor,
  output logic done,
  output logic [15:0] quotient,
  output logic [15:0] remainder
);
  amc_pkg::amc_div_state_t state;
  logic [4:0] count;
  logic [15:0] quo;
  logic [16:0] rem;
  logic [15:0] dsr;
  logic neg_q;
  logic neg_r;
  wire dvd_neg = is_signed & dividend[15];
  wire dsr_neg = is_signed & divisor[15];
  wire [15:0] dvd_abs = dvd_neg ? 16'(-dividend) : dividend;
  wire [15:0] dsr_abs = dsr_neg ? 16'(-divisor) : divisor;
  wire [16:0] shifted = {rem[15:0], quo[15]};
  wire [16:0] trial = 17'(shifted - {1'b0, dsr});
  wire fits = ~trial[16];
  wire last = (count == amc_pkg::DIV_STEPS - 5'h01);

  // one setup cycle, 16 steps, one sign-fix cycle: 18 cycles to done
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= amc_pkg::AMC_DIV_IDLE;
      count <= 5'h00;
      quo <= 16'h0000;
      rem <= 17'h0_0000;
      dsr <= 16'h0000;
      neg_q <= 1'b0;
      neg_r <= 1'b0;
      done <= 1'b0;
      quotient <= 16'h0000;
      remainder <= 16'h0000;
    end else begin
      done <= 1'b0;
      unique case (state)
        amc_pkg::AMC_DIV_IDLE: begin
          if (start) begin
            quo <= dvd_abs;
            dsr <= dsr_abs;
            rem <= 17'h0_0000;
            count <= 5'h00;
            neg_q <= dvd_neg ^ dsr_neg;
            neg_r <= dvd_neg;
            state <= amc_pkg::AMC_DIV_RUN;
          end
        end
        amc_pkg::AMC_DIV_RUN: begin
          rem <= fits ? trial : shifted;
          quo <= {quo[14:0], fits};
          count <= 5'(count + 5'h01);
          if (last) begin
            state <= amc_pkg::AMC_DIV_FIX;
          end
        end
        amc_pkg::AMC_DIV_FIX: begin
          // divide by zero gives all-ones magnitude quotient and the dividend as remainder
          quotient <= neg_q ? 16'(-quo) : quo;
          remainder <= neg_r ? 16'(-rem[15:0]) : rem[15:0];
          done <= 1'b1;
          state <= amc_pkg::AMC_DIV_IDLE;
        end
        default: begin
          state <= amc_pkg::AMC_DIV_IDLE;
        end
      endcase
    end
  end
endmodule

/* File: verilog/amc_arith_coprocessor.sv */
// arithmetic coprocessor: multiply, multiply-accumulate, divide, 32-bit result register
// assumes the core drives the instruction strobes on CLK and stalls while BUSY is high
`timescale 1ns/1ps
module amc_arith_coprocessor (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic MODE_WRITE_INSTR,
  input wire logic OPERAND_SEND_INSTR,
  input wire logic PRELOAD_SEND_INSTR,
  input wire logic [15:0] SRC_DATA,
  input wire logic [15:0] DST_DATA,
  output logic [15:0] RESULT_DATA,
  output logic RESULT_VALID,
  output logic [3:0] FLAGS,
  output logic BUSY
);
  logic rst_meta;
  logic rst_sync;
  logic [amc_pkg::MODE_W-1:0] operation_mode_select;
  logic [amc_pkg::RES_W-1:0] result;
  logic div_active;
  logic div_done;
  logic [15:0] div_quo;
  logic [15:0] div_rem;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  wire [amc_pkg::OP_W-1:0] op = operation_mode_select[amc_pkg::OP_LSB +: amc_pkg::OP_W];
  wire [amc_pkg::SEL_W-1:0] sel = operation_mode_select[amc_pkg::SEL_LSB +: amc_pkg::SEL_W];

  wire op_mul = (op == amc_pkg::OP_MULU) | (op == amc_pkg::OP_MULS);
  wire op_mac = (op == amc_pkg::OP_MAC);
  wire op_div = (op == amc_pkg::OP_DIVU) | (op == amc_pkg::OP_DIVS);
  wire op_read = (op == amc_pkg::OP_READ);
  wire op_signed = (op == amc_pkg::OP_MULS) | op_mac | (op == amc_pkg::OP_DIVS);

  // operand A comes from the destination register, operand B from source or immediate
  wire signed [16:0] a_ext = {op_signed & DST_DATA[15], DST_DATA};
  wire signed [16:0] b_ext = {op_signed & SRC_DATA[15], SRC_DATA};
  wire signed [33:0] prod_full = a_ext * b_ext;
  wire [31:0] product = prod_full[31:0];

  // signed overflow: operands share a sign the sum does not have
  wire [31:0] mac_sum = 32'(result + product);
  wire mac_ovf = (result[31] == product[31]) & (mac_sum[31] != result[31]);

  wire take_op = OPERAND_SEND_INSTR & ~div_active;
  wire take_pre = PRELOAD_SEND_INSTR & ~div_active;
  wire div_start = take_op & op_div;

  wire [31:0] preload16 = {16'h0000, SRC_DATA};
  wire [31:0] preload32 = {DST_DATA, SRC_DATA};
  wire [31:0] div_result = {div_rem, div_quo};

  logic [31:0] next_result;
  always_comb begin
    next_result = result;
    if (div_done) begin
      next_result = div_result;
    end else if (MODE_WRITE_INSTR & ~div_active &
                 (SRC_DATA[amc_pkg::OP_LSB +: amc_pkg::OP_W] == amc_pkg::OP_CLEAR)) begin
      next_result = amc_pkg::RES_RESET;
    end else if (take_pre & (op == amc_pkg::OP_LOAD16)) begin
      next_result = preload16;
    end else if (take_pre & (op == amc_pkg::OP_LOAD32)) begin
      next_result = preload32;
    end else if (take_op & op_mul) begin
      next_result = product;
    end else if (take_op & op_mac) begin
      next_result = mac_sum;
    end
    // read and reserved codes fall through unchanged
  end

  function automatic logic [15:0] pick_half(input logic [2:0] s, input logic [31:0] v);
    logic [15:0] h;
    h = amc_pkg::RESERVED_ANSWER;
    if (s == amc_pkg::SEL_LOW) begin
      h = v[15:0];
    end else if (s == amc_pkg::SEL_HIGH) begin
      h = v[31:16];
    end
    return h;
  endfunction

  wire answer_now = take_op & (op_mul | op_mac | op_read);
  wire answer_reserved = take_op & ~(op_mul | op_mac | op_read | op_div);
  wire [15:0] answer_val = answer_reserved ? amc_pkg::RESERVED_ANSWER : pick_half(sel, next_result);
  wire [3:0] mac_flags = {1'b0, mac_ovf, 2'b00};

  always_ff @(posedge CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      operation_mode_select <= amc_pkg::MODE_RESET;
      result <= amc_pkg::RES_RESET;
      div_active <= 1'b0;
      RESULT_DATA <= 16'h0000;
      RESULT_VALID <= 1'b0;
      FLAGS <= amc_pkg::FLAGS_CLEAR;
      BUSY <= 1'b0;
    end else begin
      result <= next_result;
      if (MODE_WRITE_INSTR & ~div_active) begin
        operation_mode_select <= SRC_DATA[amc_pkg::MODE_W-1:0];
      end
      if (div_start) begin
        div_active <= 1'b1;
      end else if (div_done) begin
        div_active <= 1'b0;
      end
      BUSY <= div_start | (div_active & ~div_done);
      RESULT_VALID <= answer_now | answer_reserved | div_done;
      if (div_done) begin
        RESULT_DATA <= pick_half(sel, div_result);
        FLAGS <= amc_pkg::FLAGS_CLEAR;
      end else if (answer_now | answer_reserved) begin
        RESULT_DATA <= answer_val;
        FLAGS <= op_mac ? mac_flags : amc_pkg::FLAGS_CLEAR;
      end
    end
  end

  amc_divider u_div (
    .clk(CLK),
    .rst_b(rst_sync),
    .start(div_start),
    .is_signed(op == amc_pkg::OP_DIVS),
    .dividend(DST_DATA),
    .divisor(SRC_DATA),
    .done(div_done),
    .quotient(div_quo),
    .remainder(div_rem)
  );
endmodule

/* File: tb/amc_arith_sva.sv */
// port checker for the arithmetic coprocessor
// assumes the core stalls on BUSY; bound to every coprocessor instance
`timescale 1ns/1ps
module amc_arith_checker (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic MODE_WRITE_INSTR,
  input wire logic OPERAND_SEND_INSTR,
  input wire logic PRELOAD_SEND_INSTR,
  input wire logic [15:0] SRC_DATA,
  input wire logic [15:0] DST_DATA,
  input wire logic [15:0] RESULT_DATA,
  input wire logic RESULT_VALID,
  input wire logic [3:0] FLAGS,
  input wire logic BUSY
);
  logic [6:0] mode;
  wire take = OPERAND_SEND_INSTR && !BUSY;
  wire [3:0] op = mode[3:0];
  wire [2:0] sel = mode[6:4];
  wire [31:0] pu = DST_DATA * SRC_DATA;
  wire signed [31:0] ps = $signed(DST_DATA) * $signed(SRC_DATA);
  wire [31:0] pm = op[0] ? ps : pu;
  wire [15:0] half = sel[0] ? pm[31:16] : pm[15:0];
  wire divop = op[3:1] == 3'h4;
  wire rsvd = !divop && (op == 4'h6 || op > 4'h9 || sel > 3'h1);
  // shadow of the write-only mode register
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode <= 7'h00;
    end else if (MODE_WRITE_INSTR && !BUSY) begin
      mode <= SRC_DATA[6:0];
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  a_mul_value: assert property (take && op[3:1] == 3'h2 && sel < 3'h2
    |=> RESULT_DATA == $past(half) && FLAGS == 4'h0) else $error("multiply answer wrong");
  a_answer_next: assert property (take && op > 4'h2 && !divop
    |=> RESULT_VALID) else $error("answer missing");
  a_reserved_zero: assert property (take && rsvd
    |=> RESULT_DATA == 16'h0000) else $error("reserved answer not zero");
  a_div_busy: assert property (take && divop
    |=> BUSY [*8] ##1 BUSY [*8] ##1 BUSY [*2] ##1 (!BUSY && RESULT_VALID && FLAGS == 4'h0))
    else $error("divide timing wrong");
  a_silent_write: assert property ((MODE_WRITE_INSTR || PRELOAD_SEND_INSTR) && !OPERAND_SEND_INSTR && !BUSY
    |=> !RESULT_VALID) else $error("answer without operand send");
  a_mac_flags: assert property (take && op == 4'h7
    |=> FLAGS[3] == 1'b0 && FLAGS[1:0] == 2'h0) else $error("mac flags wrong");
  // a divide leaves the old flags standing until its own answer
  a_flags_clear: assert property (take && op != 4'h7 && !divop
    |=> FLAGS == 4'h0) else $error("flags not clear");
  a_busy_cause: assert property (!BUSY && !take |=> !BUSY) else $error("busy without divide");
  c_divide: cover property (take && divop);
  c_mac: cover property (take && op == 4'h7);
  c_reserved: cover property (take && rsvd);
endmodule
bind amc_arith_coprocessor amc_arith_checker u_chk (.CLK, .RST_B, .MODE_WRITE_INSTR, .OPERAND_SEND_INSTR,
  .PRELOAD_SEND_INSTR, .SRC_DATA, .DST_DATA, .RESULT_DATA, .RESULT_VALID, .FLAGS, .BUSY);

/* File: tb/amc_host_model.sv */
// host core model: issues one coprocessor instruction per call
// assumes the caller waits out BUSY before issuing again
`timescale 1ns/1ps
module amc_host_model (
  input wire logic clk,
  output logic mode_write_instr,
  output logic operand_send_instr,
  output logic preload_send_instr,
  output logic [15:0] src_data,
  output logic [15:0] dst_data
);
  initial begin
    mode_write_instr = 1'b0;
    operand_send_instr = 1'b0;
    preload_send_instr = 1'b0;
    src_data = 16'h0000;
    dst_data = 16'h0000;
  end
  // kind 0 mode write, 1 operand send, 2 preload send
  task issue(input int kind, input logic [15:0] dst, input logic [15:0] src);
    @(posedge clk);
    mode_write_instr <= kind == 0;
    operand_send_instr <= kind == 1;
    preload_send_instr <= kind == 2;
    dst_data <= dst;
    src_data <= src;
  endtask
  // released registers show the inverse, never a held value
  task idle();
    @(posedge clk);
    mode_write_instr <= 1'b0;
    operand_send_instr <= 1'b0;
    preload_send_instr <= 1'b0;
    dst_data <= ~dst_data;
    src_data <= ~src_data;
  endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench: every operation code and selector against a reference model
// assumes the host model drives instructions and the checker is bound to the coprocessor
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic mw, os, ps, rvalid, busy;
  logic [15:0] src, dst, rdata;
  logic [3:0] flags;
  logic [31:0] lfsr_s = 32'h8f2f_ea02;
  logic [31:0] res_m = 32'h0000_0000;
  int n_errors = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  amc_host_model host (.clk(clk), .mode_write_instr(mw), .operand_send_instr(os), .preload_send_instr(ps),
    .src_data(src), .dst_data(dst));
  amc_arith_coprocessor dut (.CLK(clk), .RST_B(rst_b), .MODE_WRITE_INSTR(mw), .OPERAND_SEND_INSTR(os),
    .PRELOAD_SEND_INSTR(ps), .SRC_DATA(src), .DST_DATA(dst), .RESULT_DATA(rdata), .RESULT_VALID(rvalid),
    .FLAGS(flags), .BUSY(busy));
  function automatic logic [15:0] rnd();
    lfsr_s = {lfsr_s[30:0], lfsr_s[31] ^ lfsr_s[21] ^ lfsr_s[1] ^ lfsr_s[0]};
    return lfsr_s[15:0];
  endfunction
  task give_verdict();
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task cmp_data(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cmp_flags(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // called in the take edge's time step; n counts edges after the take edge
  // the one-cycle answer of a multiply is already up just after the take edge
  task wait_answer(output int n);
    n = 0;
    #1;
    while (rvalid !== 1'b1 && n < 30) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (rvalid !== 1'b1) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic do_op(input logic [3:0] op, input logic [2:0] sel, input logic [15:0] a, input logic [15:0] b);
    logic [31:0] p;
    logic [15:0] e;
    longint s;
    logic v;
    logic rsv;
    int n;
    host.issue(0, rnd(), {9'h000, sel, op});
    if (op == 4'h0) res_m = 32'h0000_0000;
    if (op == 4'h1 || op == 4'h2) host.issue(2, a, b);
    if (op == 4'h1) res_m = {16'h0000, b};
    if (op == 4'h2) res_m = {a, b};
    if (op < 4'h3) begin
      host.idle();
      return;
    end
    host.issue(1, a, b);
    host.idle();
    if (op == 4'h4) p = a * b;
    else p = $signed(a) * $signed(b);
    s = longint'($signed(res_m)) + longint'($signed(p));
    v = 1'b0;
    case (op)
      4'h4, 4'h5: res_m = p;
      4'h7: begin
        res_m = s[31:0];
        v = s != longint'($signed(s[31:0]));
      end
      4'h8: res_m = {a % b, a / b};
      4'h9: res_m = {16'($signed(a) % $signed(b)), 16'($signed(a) / $signed(b))};
      default: ;
    endcase
    rsv = op == 4'h6 || op > 4'h9 || sel > 3'h1;
    e = rsv ? 16'h0000 : (sel == 3'h0 ? res_m[15:0] : res_m[31:16]);
    wait_answer(n);
    cmp_data(16'(n), op[3:1] == 3'h4 ? 16'h0012 : 16'h0000);
    cmp_data(rdata, e);
    cmp_flags(flags, {1'b0, v, 2'h0});
  endtask
  initial begin
    logic [15:0] a;
    logic [15:0] b;
    logic [2:0] s;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    do_op(4'h3, 3'h0, rnd(), rnd());
    for (int i = 0; i < 48; i++) begin
      a = rnd();
      // odd divisor with bit 1 clear never divides by zero or minus one
      b = (rnd() & 16'hfffd) | 16'h0001;
      s = i < 32 ? 3'(i / 16) : 3'h2 + 3'(rnd() % 6);
      do_op(4'h2, 3'h0, rnd(), rnd());
      do_op(4'(i), s, a, b);
      do_op(4'h3, 3'h0, a, b);
      do_op(4'h3, 3'h1, a, b);
    end
    do_op(4'h2, 3'h0, 16'h7fff, 16'hffff);
    do_op(4'h7, 3'h1, 16'h7fff, 16'h7fff);
    give_verdict();
  end
endmodule
